// ---- hw/pcs_sequencer.sv ----
// Program counter sequencer: four-phase instruction cycle, two-stage
// fetch/execute pipeline, 13-bit counter, vectors and an APB window.
// Assumes an external decoder that flags the kind of the instruction in
// insn for the whole cycle, and an external 16-level return stack.
`default_nettype none

module pcs_sequencer
    import pcs_pkg::*;
(
    input wire logic pclk,                 // System clock
    input wire logic presetn,              // Asynchronous reset, active low
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB access phase
    input wire logic pwrite,               // APB write
    input wire logic [31:0] paddr,         // APB byte address
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error on unmapped address
    input wire logic wake_from_halt,       // Wake pulse, restarts start-up wait
    input wire logic [15:0] pmem_data,     // Program word at pmem_addr
    output logic [12:0] pmem_addr,         // Program memory fetch address
    output logic [15:0] insn,              // Word under execution
    output logic insn_valid,               // insn is a real instruction
    output logic [1:0] phase,              // Current phase of the cycle
    output logic cycle_end,                // Last phase of the cycle
    input wire logic dec_jump,             // insn is a jump
    input wire logic dec_call,             // insn is a call
    input wire logic dec_return,           // insn is return_from_sub or return_from_irq
    input wire logic dec_skip_taken,       // insn is a skip whose condition holds
    input wire logic [12:0] dec_target,    // Address field of jump or call
    input wire logic [5:0] irq_req,        // Enabled interrupt requests
    output logic [5:0] irq_ack,            // Acknowledge pulse per source
    input wire logic stack_full,           // Return stack holds 16 entries
    input wire logic [12:0] stack_top,     // Top return stack entry
    output logic stack_push,               // Push pulse
    output logic stack_pop,                // Pop pulse
    output logic [12:0] stack_push_data    // Value to push
);

    pcs_mode_t mode;
    logic [10:0] startup_cnt;
    logic [12:0] pc;
    logic dummy;
    logic [5:0] irq_pend;
    logic pcl_pend;
    logic [7:0] pcl_value;

    logic boundary;
    logic exec_now;
    logic seq_insn;
    logic irq_go;
    logic [2:0] irq_sel;
    logic [12:0] irq_vec;
    logic [12:0] pc_inc;
    logic [12:0] next_pc;
    logic next_dummy;
    logic apb_setup;
    logic wr_pcl;
    logic [5:0] next_ack;

    // Vector table, indexed by source priority
    function automatic logic [12:0] pcs_vector(input logic [2:0] idx);
        logic [12:0] v;
        v = VEC_EXT0;
        case (idx)
            3'h0: v = VEC_EXT0;
            3'h1: v = VEC_EXT1;
            3'h2: v = VEC_TMR0;
            3'h3: v = VEC_TMR1;
            3'h4: v = VEC_TBASE;
            3'h5: v = VEC_RTC;
            default: v = VEC_EXT0;
        endcase
        return v;
    endfunction : pcs_vector

    // Phase counter runs freely; the cycle ends on the last phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= 2'h0;
            cycle_end <= 1'b0;
        end
        else
        begin
            phase <= phase + 2'h1;
            cycle_end <= (phase == PHASE_LAST - 2'h1);
        end
    end

    assign boundary = (phase == PHASE_LAST);

    // Start-up wait after reset and after every wake-up from halt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= PCS_STARTUP;
            startup_cnt <= 11'h000;
        end
        else if (wake_from_halt)
        begin
            mode <= PCS_STARTUP;
            startup_cnt <= 11'h000;
        end
        else
        begin
            case (mode)
                PCS_STARTUP:
                begin
                    if (startup_cnt == STARTUP_LAST)
                    begin
                        mode <= PCS_RUN;
                    end
                    else
                    begin
                        startup_cnt <= startup_cnt + 11'h001;
                    end
                end
                PCS_RUN: startup_cnt <= 11'h000;
                default: mode <= PCS_STARTUP;
            endcase
        end
    end

    // The word in insn is executed only when valid and not a dummy slot
    assign exec_now = (mode == PCS_RUN) && boundary && insn_valid && !dummy;
    assign seq_insn = !(dec_jump || dec_call || dec_return || dec_skip_taken);

    // Pick the highest priority latched request
    always_comb
    begin
        irq_sel = 3'h0;
        for (int i = IRQ_N - 1; i >= 0; i--)
        begin
            if (irq_pend[i])
            begin
                irq_sel = 3'(i);
            end
        end
    end

    assign irq_vec = pcs_vector(irq_sel);
    // Taken only between sequential instructions, so nothing is half done,
    // and never while the stack is full
    assign irq_go = exec_now && seq_insn && !pcl_pend && (|irq_pend) && !stack_full;
    assign pc_inc = pc + PC_ONE;

    // Next counter value and whether the following cycle is a dummy
    always_comb
    begin
        next_pc = pc;
        next_dummy = 1'b0;
        if (mode != PCS_RUN)
        begin
            next_pc = pc;
            next_dummy = 1'b0;
        end
        else if (exec_now && dec_return)
        begin
            next_pc = stack_top;
            next_dummy = 1'b1;
        end
        else if (exec_now && (dec_jump || dec_call))
        begin
            next_pc = dec_target;
            next_dummy = 1'b1;
        end
        else if (exec_now && dec_skip_taken)
        begin
            next_pc = pc_inc;
            next_dummy = 1'b1;
        end
        else if (irq_go)
        begin
            next_pc = irq_vec;
            next_dummy = 1'b1;
        end
        else if (pcl_pend && (exec_now || dummy || !insn_valid))
        begin
            next_pc = {pc[12:8], pcl_value};
            next_dummy = insn_valid;
        end
        else
        begin
            next_pc = pc_inc;
            next_dummy = 1'b0;
        end
    end

    // Counter, fetch register and dummy marker step once per cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc <= PC_RESET;
            insn <= 16'h0000;
            insn_valid <= 1'b0;
            dummy <= 1'b0;
        end
        else if (mode != PCS_RUN)
        begin
            insn_valid <= 1'b0;
            dummy <= 1'b0;
        end
        else if (boundary)
        begin
            pc <= next_pc;
            insn <= pmem_data;
            insn_valid <= !next_dummy;
            dummy <= next_dummy;
        end
    end

    // The fetch address is the counter itself
    assign pmem_addr = pc;

    // Stack strobes and interrupt acknowledges
    always_comb
    begin
        next_ack = 6'h00;
        if (irq_go)
        begin
            next_ack[irq_sel] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stack_push <= 1'b0;
            stack_pop <= 1'b0;
            stack_push_data <= 13'h0000;
            irq_ack <= 6'h00;
        end
        else
        begin
            // Call pushes the word after it; an acknowledge pushes the dropped word
            stack_push <= (exec_now && dec_call) || irq_go;
            stack_pop <= exec_now && dec_return;
            stack_push_data <= pc;
            irq_ack <= next_ack;
        end
    end

    // Latched requests: a new request wins over the clear of its acknowledge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pend <= 6'h00;
        end
        else
        begin
            irq_pend <= (irq_pend & ~next_ack) | irq_req;
        end
    end

    // APB decode
    assign apb_setup = psel && !penable;
    assign wr_pcl = psel && penable && pready && pwrite && (paddr == PC_LOW_BYTE_ADDR);

    // Software low byte write waits for a cycle boundary where it can apply
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pcl_pend <= 1'b0;
            pcl_value <= PC_LOW_BYTE_RESET;
        end
        else if (wr_pcl)
        begin
            pcl_pend <= 1'b1;
            pcl_value <= pwdata[7:0];
        end
        else if ((mode == PCS_RUN) && boundary && !irq_go && (next_pc == {pc[12:8], pcl_value})
                 && pcl_pend && (exec_now || dummy || !insn_valid) && !(exec_now && !seq_insn))
        begin
            pcl_pend <= 1'b0;
        end
    end

    // One wait state: the answer comes in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (apb_setup)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= !((paddr == PC_LOW_BYTE_ADDR) || (paddr == SEQ_STATUS_ADDR));
            prdata <= 32'h0000_0000;
            if (!pwrite && (paddr == PC_LOW_BYTE_ADDR))
            begin
                prdata <= {24'h000000, pc[7:0]};
            end
            else if (!pwrite && (paddr == SEQ_STATUS_ADDR))
            begin
                prdata[ST_RUN_BIT] <= (mode == PCS_RUN);
                prdata[ST_DUMMY_BIT] <= dummy;
                prdata[ST_PEND_BIT] <= pcl_pend;
                prdata[ST_PC_LSB +: PC_W] <= pc;
            end
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : pcs_sequencer

`default_nettype wire

// ---- include/pcs_pkg.sv ----
// Constants and types shared by the program counter sequencer.
// Assumes a 125 MHz pclk that also serves as the core's system clock.
`default_nettype none

package pcs_pkg;

    // Clock and start-up timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int STARTUP_SYS_PERIODS = 1024;
    // One system clock period is one pclk period here
    localparam int STARTUP_CYCLES = (STARTUP_SYS_PERIODS * CLK_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int STARTUP_W = 11;
    localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);

    // Instruction cycle phases
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_LAST = 2'(PHASES - 1);

    // Program counter and memory geometry
    localparam int PC_W = 13;
    localparam int PMEM_WORDS = 8192;
    localparam int INSN_W = 16;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [12:0] PC_ONE = 13'h0001;

    // Interrupt sources and vectors, lowest index has highest priority
    localparam int IRQ_N = 6;
    localparam logic [12:0] VEC_EXT0 = 13'h0004;
    localparam logic [12:0] VEC_EXT1 = 13'h0008;
    localparam logic [12:0] VEC_TMR0 = 13'h000c;
    localparam logic [12:0] VEC_TMR1 = 13'h0010;
    localparam logic [12:0] VEC_TBASE = 13'h0014;
    localparam logic [12:0] VEC_RTC = 13'h0018;

    // Register indices and byte addresses
    localparam logic [7:0] PC_LOW_BYTE_IDX = 8'h06;
    localparam logic [31:0] PC_LOW_BYTE_ADDR = 32'h0000_0018;
    localparam logic [31:0] SEQ_STATUS_ADDR = 32'h0000_0040;
    localparam logic [7:0] PC_LOW_BYTE_RESET = 8'h00;

    // Status register field positions
    localparam int ST_RUN_BIT = 0;
    localparam int ST_DUMMY_BIT = 1;
    localparam int ST_PEND_BIT = 2;
    localparam int ST_PC_LSB = 16;

    // Sequencer mode
    typedef enum logic [0:0] {
        PCS_STARTUP = 1'b0,
        PCS_RUN = 1'b1
    } pcs_mode_t;

endpackage : pcs_pkg

`default_nettype wire

// ---- tb/pcs_seq_asserts.sv ----
// Concurrent checks on the sequencer's ports, attached by bind.
// Assumes the one pclk domain with presetn as its asynchronous reset.
`default_nettype none
module pcs_seq_asserts
    import pcs_pkg::*;
(
    input wire logic pclk,                   // Clock
    input wire logic presetn,                // Reset, active low
    input wire logic psel,                   // APB select
    input wire logic penable,                // APB access
    input wire logic pready,                 // APB ready
    input wire logic pslverr,                // APB error
    input wire logic wake_from_halt,         // Wake pulse
    input wire logic [12:0] pmem_addr,       // Counter
    input wire logic insn_valid,             // Real instruction
    input wire logic [1:0] phase,            // Phase
    input wire logic cycle_end,              // Last phase
    input wire logic dec_jump,               // Jump flag
    input wire logic dec_call,               // Call flag
    input wire logic dec_return,             // Return flag
    input wire logic dec_skip_taken,         // Skip flag
    input wire logic [12:0] dec_target,      // Jump address
    input wire logic [5:0] irq_ack,          // Acknowledges
    input wire logic stack_full,             // Stack full
    input wire logic [12:0] stack_top,       // Stack top
    input wire logic stack_push,             // Push pulse
    input wire logic stack_pop,              // Pop pulse
    input wire logic [12:0] stack_push_data  // Pushed value
);
    logic go;
    logic [10:0] cnt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A boundary that executes a real instruction
    assign go = cycle_end && insn_valid;
    // Clocks since reset or wake, saturating so it never wraps into a false hold
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cnt <= 11'h0;
        else if (wake_from_halt)
            cnt <= 11'h0;
        else if (cnt != 11'h7ff)
            cnt <= cnt + 11'h1;
    a_phase_cycle: assert property (cycle_end |-> phase == 2'd3 ##1 phase == 2'd0
        ##1 phase == 2'd1 ##1 phase == 2'd2 ##1 cycle_end) else $error("phase order broken");
    a_hold_midcycle: assert property (!cycle_end |=> $stable(pmem_addr))
        else $error("counter moved mid cycle");
    a_seq_step: assert property (go && !dec_jump && !dec_call && !dec_return &&
        !dec_skip_taken |=> !insn_valid || pmem_addr == $past(pmem_addr) + 13'd1)
        else $error("counter not incremented");
    a_jump_load: assert property (go && dec_jump && !dec_return |=>
        pmem_addr == $past(dec_target) && !insn_valid) else $error("jump target wrong");
    a_call_push: assert property (go && dec_call && !dec_return |=>
        stack_push && stack_push_data == $past(pmem_addr)) else $error("call push wrong");
    a_return_pop: assert property (go && dec_return |=>
        stack_pop && pmem_addr == $past(stack_top)) else $error("return load wrong");
    a_skip_drop: assert property (go && dec_skip_taken && !dec_jump && !dec_call &&
        !dec_return |=> !insn_valid && pmem_addr == $past(pmem_addr) + 13'd1)
        else $error("skip resume wrong");
    a_irq_vector: assert property (irq_ack != 6'h0 |-> stack_push && $onehot(irq_ack)
        && pmem_addr == {5'h0, irq_ack == 6'h1 ? 8'h04 : irq_ack == 6'h2 ? 8'h08 :
        irq_ack == 6'h4 ? 8'h0c : irq_ack == 6'h8 ? 8'h10 : irq_ack == 6'h10 ? 8'h14 : 8'h18})
        else $error("vector wrong");
    a_irq_full: assert property (irq_ack != 6'h0 |-> !$past(stack_full))
        else $error("vectored with full stack");
    a_dummy_len: assert property ($fell(insn_valid) |-> !insn_valid [*4])
        else $error("dummy cycle too short");
    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after wait state");
    a_startup_hold: assert property (cnt > 11'd4 && cnt < 11'd1020 |-> !insn_valid)
        else $error("ran during start-up");
    c_jump: cover property (go && dec_jump);
    c_irq: cover property (irq_ack != 6'h0);
    c_full: cover property (stack_full && cycle_end);
    c_err: cover property (pslverr);
endmodule : pcs_seq_asserts
bind pcs_sequencer pcs_seq_asserts chk (.*);
`default_nettype wire

// ---- tb/pcs_prog_stack_model.sv ----
// Program memory and return stack at the sequencer's far side.
// Assumes pulses from the sequencer; memory is combinational.
`default_nettype none
module pcs_prog_stack_model
    import pcs_pkg::*;
(
    input wire logic pclk,                   // Clock
    input wire logic presetn,                // Reset, active low
    input wire logic [12:0] pmem_addr,       // Fetch address
    output logic [15:0] pmem_data,           // Fetched word
    input wire logic stack_push,             // Push pulse
    input wire logic stack_pop,              // Pop pulse
    input wire logic [12:0] stack_push_data, // Pushed value
    output logic stack_full,                 // All levels used
    output logic [12:0] stack_top            // Newest entry
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] stk [16];
    logic [3:0] ptr;
    logic [4:0] cnt;
    // Each word carries 3'h5 above its own address so fetches are traceable
    assign pmem_data = {3'h5, pmem_addr};
    assign stack_full = cnt == 5'd16;
    assign stack_top = stk[ptr - 4'd1];
    // Sixteen levels; a push when full overwrites the oldest entry
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ptr <= 4'h0;
            cnt <= 5'h0;
        end
        else if (stack_push)
        begin
            stk[ptr] <= stack_push_data;
            ptr <= ptr + 4'd1;
            cnt <= cnt + 5'(cnt != 5'd16);
        end
        else if (stack_pop)
        begin
            ptr <= ptr - 4'd1;
            cnt <= cnt - 5'(cnt != 5'd0);
        end
endmodule : pcs_prog_stack_model
`default_nettype wire

// ---- tb/test_program_counter_sequencer.sv ----
// Random and directed bench for the sequencer with its memory and stack model.
// Assumes one 125 MHz clock; decoder flags are driven here.
`default_nettype none
module test_program_counter_sequencer
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic wake_from_halt = 1'b0, pready, pslverr, insn_valid, cycle_end, stack_full;
    logic stack_push, stack_pop, er;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [15:0] pmem_data, insn;
    logic [12:0] dec_target = 13'h0, pmem_addr, stack_top, stack_push_data, pc0, tp, ca, e;
    logic [7:0] d;
    logic [5:0] irq_req = 6'h0, irq_ack;
    logic [3:0] fl = 4'h0, f;
    logic [1:0] phase;
    int err_count = 0, checks = 0, seed = 32'h854a95f1, bad;
    // Free-running 8 ns clock
    always #4 pclk = ~pclk;
    pcs_sequencer uut (.*, .dec_jump(fl[3]), .dec_call(fl[2]), .dec_return(fl[1]),
        .dec_skip_taken(fl[0]));
    pcs_prog_stack_model m (.*);
    task results;
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    task chk(input logic ok, input string s);
        checks++;
        if (!ok)
        begin
            err_count++;
            $display("mismatch %0t %s", $time, s);
        end
    endtask : chk
    task hang(input int n);
        if (n >= 3000)
        begin
            chk(1'b0, "timeout");
            results();
        end
    endtask : hang
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 3000);
        hang(n);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Flags are raised for the phase-3 cycle only; settled values are read at negedge
    task step(input logic [3:0] sf, input logic [12:0] t, input logic [5:0] q);
        int n;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (!(phase === 2'd2 && insn_valid === 1'b1) && n < 3000);
        hang(n);
        pc0 = pmem_addr;
        tp = stack_top;
        chk(insn === {3'h5, pc0 - 13'd1}, "fetched word");
        @(posedge pclk);
        fl <= sf;
        dec_target <= t;
        irq_req <= q;
        @(posedge pclk);
        fl <= 4'h0;
        irq_req <= 6'h0;
        @(negedge pclk);
        e = sf[1] ? tp : (sf[3] | sf[2]) ? t : pc0 + 13'd1;
        chk(pmem_addr === e || irq_ack !== 6'h0, "next counter");
        chk(irq_ack === 6'h0 || sf === 4'h0, "irq during transfer");
        chk(insn_valid === (sf === 4'h0 && irq_ack === 6'h0), "dummy cycle");
    endtask : step
    // Main sequence: registers, directed transfers, random traffic, wake
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SEQ_STATUS_ADDR, 32'h0);
        chk(rd[ST_RUN_BIT] === 1'b0 && rd[28:16] === PC_RESET, "start state");
        apb(1'b0, PC_LOW_BYTE_ADDR, 32'h0);
        chk(rd === 32'h0 && er === 1'b0, "low byte reset");
        apb(1'b1, 32'h0000_0044, 32'hff);
        chk(er === 1'b1, "unmapped write");
        step(4'h8, 13'h1fff, 6'h0);
        step(4'h0, 13'h0, 6'h0);
        chk(pc0 === 13'h0, "wrap to zero");
        step(4'h4, 13'h0123, 6'h0);
        ca = pc0;
        step(4'h1, 13'h0, 6'h0);
        step(4'h2, 13'h0, 6'h0);
        chk(pmem_addr === ca, "return address");
        for (int i = 0; i < 6; i++)
        begin
            // The request is latched at one boundary and served at the next
            step(4'h0, 13'h0, 6'(1 << i));
            step(4'h0, 13'h0, 6'h0);
            chk(pmem_addr === 13'((i + 1) * 4), "vector");
        end
        repeat (16) step(4'h4, 13'h0200, 6'h0);
        step(4'h0, 13'h0, 6'h2);
        chk(irq_ack === 6'h0, "irq with full stack");
        step(4'h2, 13'h0, 6'h0);
        step(4'h0, 13'h0, 6'h0);
        chk(irq_ack === 6'h2, "held irq served");
        repeat (150)
        begin
            f = 4'(5'h1 << ($unsigned($random(seed)) % 5));
            if (f == 4'h2 && m.cnt == 5'h0)
                f = 4'h0;
            step(f, 13'($random(seed)), ($random(seed) & 3) == 0 ? 6'($random(seed)) : 6'h0);
        end
        repeat (8) step(4'h0, 13'h0, 6'h0);
        d = 8'($random(seed));
        apb(1'b1, PC_LOW_BYTE_ADDR, {24'hffffff, d});
        bad = 0;
        while (insn_valid === 1'b1 && bad < 3000)
        begin
            tp = pmem_addr;
            @(negedge pclk);
            bad++;
        end
        hang(bad);
        chk(pmem_addr === {tp[12:8], d}, "low byte jump");
        apb(1'b0, PC_LOW_BYTE_ADDR, 32'h0);
        chk(rd[31:8] === 24'h0 && er === 1'b0, "low byte read");
        @(posedge pclk);
        wake_from_halt <= 1'b1;
        @(posedge pclk);
        wake_from_halt <= 1'b0;
        bad = 0;
        repeat (8) @(negedge pclk);
        repeat (1000)
        begin
            @(negedge pclk);
            if (insn_valid !== 1'b0)
                bad++;
        end
        chk(bad === 0, "start-up hold");
        step(4'h0, 13'h0, 6'h0);
        results();
    end
endmodule : test_program_counter_sequencer
`default_nettype wire
